// ---- core/scap_top.sv ----
// Scan chain access port: byte buffers, serial engine, port multiplexer
`timescale 1ns/1ps
`default_nettype none
module scap_top
    import scap_pkg::*;
#(
    parameter int unsigned PORTS      = NUM_PORTS,
    parameter int unsigned CMD_BYTES  = CMD_DEPTH,
    parameter int unsigned RESP_BYTES = RESP_DEPTH
) (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic              clk_en_i,
    // Byte write access from the debug port
    input  wire logic              bw_req_i,
    input  wire logic [LEN_W-1:0]  bw_len_i,
    input  wire logic [ACC_W-1:0]  bw_data_i,
    output logic                   bw_ack_o,
    // Byte read access from the debug port
    input  wire logic              br_req_i,
    input  wire logic [LEN_W-1:0]  br_len_i,
    output logic                   br_ack_o,
    output logic [ACC_W-1:0]       br_data_o,
    // Immediate control and status
    input  wire logic [SEL_W-1:0]  port_sel_i,
    output logic [CNT_W-1:0]       response_byte_count_o,
    output logic [CNT_W-1:0]       command_byte_count_o,
    output logic [PORTS-1:0]       port_status_reg_o,
    output logic [ACC_W-1:0]       identification_reg_o,
    output logic                   engine_busy_o,
    // Scan ports
    output logic [PORTS-1:0]       tck_o,
    output logic [PORTS-1:0]       tms_o,
    output logic [PORTS-1:0]       tdi_o,
    input  wire logic [PORTS-1:0]  tdo_i,
    input  wire logic [PORTS-1:0]  returned_scan_clock_i,
    input  wire logic [PORTS-1:0]  port_enabled_in_i
);

    initial
    begin
        if (PORTS < 1 || PORTS > NUM_PORTS)
            $error("scap_top: port count out of range");
        if (CMD_BYTES < ACC_BYTES || CMD_BYTES > CMD_MAX)
            $error("scap_top: command depth out of range");
        if (RESP_BYTES != RESP_DEPTH)
            $error("scap_top: response depth must be seven");
    end

    localparam logic [CNT_W-1:0] CMD_FULL = CNT_W'(CMD_BYTES);
    localparam logic [LEN_W-1:0] LEN_ONE  = LEN_W'(1);
    localparam logic [1:0]       IDX_ONE  = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Byte buffers
    scap_byte_if #(.W(BYTE_W), .CW(CNT_W)) cmd_if ();
    scap_byte_if #(.W(BYTE_W), .CW(CNT_W)) rsp_if ();

    scap_fifo #(.WIDTH(BYTE_W), .DEPTH(CMD_BYTES), .CW(CNT_W)) u_cmd_fifo (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .clk_en_i  (clk_en_i),
        .bus       (cmd_if.fifo)
    );

    scap_fifo #(.WIDTH(BYTE_W), .DEPTH(RESP_BYTES), .CW(CNT_W)) u_rsp_fifo (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .clk_en_i  (clk_en_i),
        .bus       (rsp_if.fifo)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every scan-side input
    logic [PORTS-1:0] tdo_s1_q;
    logic [PORTS-1:0] tdo_s2_q;
    logic [PORTS-1:0] rck_s1_q;
    logic [PORTS-1:0] rck_s2_q;
    logic [PORTS-1:0] pen_s1_q;
    logic [PORTS-1:0] pen_s2_q;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tdo_s1_q <= '0;
            tdo_s2_q <= '0;
            rck_s1_q <= '0;
            rck_s2_q <= '0;
            pen_s1_q <= '0;
            pen_s2_q <= '0;
        end
        else if (clk_en_i)
        begin
            tdo_s1_q <= tdo_i;
            tdo_s2_q <= tdo_s1_q;
            rck_s1_q <= returned_scan_clock_i;
            rck_s2_q <= rck_s1_q;
            pen_s1_q <= port_enabled_in_i;
            pen_s2_q <= pen_s1_q;
        end
    end

    // Selected port view; a port above the count reads as disabled
    wire sel_ok   = (32'(port_sel_i) < PORTS);
    wire sel_en   = sel_ok && pen_s2_q[port_sel_i];
    wire sel_tdo  = sel_ok && tdo_s2_q[port_sel_i];
    wire sel_rck  = sel_ok && rck_s2_q[port_sel_i];

    ////////////////////////////////////////////////////////////////////////
    // Serial engine state
    scap_eng_t          st_q;
    scap_eng_t          st_d;
    logic [BYTE_W-1:0]  sh_q;
    logic [BYTE_W-1:0]  sh_d;
    logic [BYTE_W-1:0]  cap_q;
    logic [BYTE_W-1:0]  cap_d;
    logic [2:0]         bits_q;
    logic [2:0]         bits_d;
    logic [DLEN_W-1:0]  left_q;
    logic [DLEN_W-1:0]  left_d;
    logic               tmsm_q;
    logic               tmsm_d;
    logic               hold_q;
    logic               hold_d;
    logic               tck_q;
    logic               tck_d;
    logic               tms_q;
    logic               tms_d;
    logic               tdi_q;
    logic               tdi_d;

    // Length of a state-change packet from its marker bit
    wire [BYTE_W-1:0] cmd_b = cmd_if.rdata;
    logic [2:0] mlen;
    always_comb
    begin
        mlen = '0;
        for (int i = 0; i < MARK_TOP; i++)
            if (cmd_b[i+1])
                mlen = 3'(i + 1);
    end

    wire eng_take = (st_q == SCAP_IDLE || st_q == SCAP_FETCH) && sel_en;
    assign cmd_if.rready = eng_take;
    assign rsp_if.wvalid = (st_q == SCAP_PUSH);
    assign rsp_if.wdata  = cap_q;

    // Engine: each bit raises the clock, waits for the return clock,
    // samples, then lowers and waits again. A chain that never returns
    // its clock holds the engine here, which is why it has no timeout.
    always_comb
    begin
        st_d   = st_q;
        sh_d   = sh_q;
        cap_d  = cap_q;
        bits_d = bits_q;
        left_d = left_q;
        tmsm_d = tmsm_q;
        hold_d = hold_q;
        tck_d  = tck_q;
        tms_d  = tms_q;
        tdi_d  = tdi_q;
        case (st_q)
            SCAP_IDLE:
            begin
                if (eng_take && cmd_if.rvalid)
                begin
                    if (!cmd_b[OPC_BIT])
                    begin
                        tmsm_d = 1'b1;
                        hold_d = cmd_b[TDI_BIT];
                        sh_d   = cmd_b;
                        bits_d = mlen - LEN_ONE;
                        st_d   = (mlen != '0) ? SCAP_SETUP : SCAP_IDLE;
                    end
                    else
                    begin
                        tmsm_d = 1'b0;
                        left_d = cmd_b[DLEN_W-1:0];
                        st_d   = SCAP_FETCH;
                    end
                end
            end
            SCAP_FETCH:
            begin
                if (eng_take && cmd_if.rvalid)
                begin
                    sh_d   = cmd_b;
                    bits_d = BIT_LAST;
                    st_d   = SCAP_SETUP;
                end
            end
            // Mode and data settle a cycle before the clock rises, so the
            // chain never sees them change on its sampling edge
            SCAP_SETUP:
            begin
                tms_d = tmsm_q & sh_q[0];
                tdi_d = tmsm_q ? hold_q : sh_q[0];
                st_d  = SCAP_RISE;
            end
            SCAP_RISE:
            begin
                tck_d = 1'b1;
                if (tck_q && sel_rck)
                begin
                    cap_d = {sel_tdo, cap_q[BYTE_W-1:1]};
                    tck_d = 1'b0;
                    st_d  = SCAP_FALL;
                end
            end
            SCAP_FALL:
            begin
                if (!sel_rck)
                begin
                    sh_d = sh_q >> 1;
                    if (bits_q != '0)
                    begin
                        bits_d = bits_q - 1'b1;
                        st_d   = SCAP_SETUP;
                    end
                    else
                        st_d = tmsm_q ? SCAP_IDLE : SCAP_PUSH;
                end
            end
            SCAP_PUSH:
            begin
                if (rsp_if.wready)
                begin
                    left_d = left_q - 1'b1;
                    st_d   = (left_q == '0) ? SCAP_IDLE : SCAP_FETCH;
                end
            end
            default:
                st_d = SCAP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q   <= SCAP_IDLE;
            sh_q   <= '0;
            cap_q  <= '0;
            bits_q <= '0;
            left_q <= '0;
            tmsm_q <= 1'b0;
            hold_q <= 1'b0;
            tck_q  <= 1'b0;
            tms_q  <= 1'b0;
            tdi_q  <= 1'b0;
        end
        else if (clk_en_i)
        begin
            st_q   <= st_d;
            sh_q   <= sh_d;
            cap_q  <= cap_d;
            bits_q <= bits_d;
            left_q <= left_d;
            tmsm_q <= tmsm_d;
            hold_q <= hold_d;
            tck_q  <= tck_d;
            tms_q  <= tms_d;
            tdi_q  <= tdi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port multiplexer: unselected ports rest with clock and data low
    genvar p;
    generate
        for (p = 0; p < PORTS; p++)
        begin : g_port
            wire hit = (32'(port_sel_i) == p);
            always_ff @(posedge ref_clk_i or posedge reset_i)
            begin
                if (reset_i)
                begin
                    tck_o[p] <= 1'b0;
                    tms_o[p] <= 1'b0;
                    tdi_o[p] <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    tck_o[p] <= hit & tck_q;
                    tms_o[p] <= hit & tms_q;
                    tdi_o[p] <= hit & tdi_q;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Byte write access: starts only when every byte fits, so the
    // pushes that follow never meet a full buffer
    logic              bw_busy_q;
    logic [LEN_W-1:0]  bw_left_q;
    logic [ACC_W-1:0]  bw_buf_q;

    wire [CNT_W-1:0] cmd_free = CMD_FULL - cmd_if.count;
    wire bw_len_ok  = (bw_len_i != '0) && (32'(bw_len_i) <= ACC_BYTES);
    wire bw_start   = bw_req_i && !bw_busy_q && !bw_ack_o && bw_len_ok
                      && (bw_len_i <= LEN_W'(cmd_free));
    wire bw_push    = bw_busy_q && cmd_if.wready;
    assign cmd_if.wvalid = bw_busy_q;
    assign cmd_if.wdata  = bw_buf_q[BYTE_W-1:0];

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            bw_busy_q <= 1'b0;
            bw_left_q <= '0;
            bw_buf_q  <= '0;
            bw_ack_o  <= 1'b0;
        end
        else if (clk_en_i)
        begin
            bw_ack_o <= bw_push && (bw_left_q == LEN_ONE);
            if (bw_start)
            begin
                bw_busy_q <= 1'b1;
                bw_left_q <= bw_len_i;
                bw_buf_q  <= bw_data_i;
            end
            else if (bw_push)
            begin
                bw_buf_q  <= bw_buf_q >> BYTE_W;
                bw_left_q <= bw_left_q - LEN_ONE;
                bw_busy_q <= (bw_left_q != LEN_ONE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte read access: starts only when n bytes are present
    logic              br_busy_q;
    logic [LEN_W-1:0]  br_left_q;
    logic [1:0]        br_idx_q;
    logic [ACC_W-1:0]  br_acc_q;
    logic [ACC_W-1:0]  br_acc_d;

    wire br_len_ok = (br_len_i != '0) && (32'(br_len_i) <= ACC_BYTES);
    wire br_start  = br_req_i && !br_busy_q && !br_ack_o && br_len_ok
                     && (br_len_i <= LEN_W'(rsp_if.count));
    wire br_pop    = br_busy_q && rsp_if.rvalid;
    assign rsp_if.rready = br_busy_q;

    // Oldest byte lands in the lowest lane
    always_comb
    begin
        br_acc_d = br_acc_q;
        br_acc_d[BYTE_W*br_idx_q +: BYTE_W] = rsp_if.rdata;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            br_busy_q <= 1'b0;
            br_left_q <= '0;
            br_idx_q  <= '0;
            br_acc_q  <= '0;
            br_ack_o  <= 1'b0;
            br_data_o <= '0;
        end
        else if (clk_en_i)
        begin
            br_ack_o <= br_pop && (br_left_q == LEN_ONE);
            if (br_start)
            begin
                br_busy_q <= 1'b1;
                br_left_q <= br_len_i;
                br_idx_q  <= '0;
                br_acc_q  <= '0;
            end
            else if (br_pop)
            begin
                br_acc_q  <= br_acc_d;
                br_idx_q  <= br_idx_q + IDX_ONE;
                br_left_q <= br_left_q - LEN_ONE;
                br_busy_q <= (br_left_q != LEN_ONE);
                if (br_left_q == LEN_ONE)
                    br_data_o <= br_acc_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status mirrors, refreshed every cycle without any scan traffic
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            response_byte_count_o <= '0;
            command_byte_count_o  <= '0;
            port_status_reg_o     <= '0;
            identification_reg_o  <= '0;
            engine_busy_o         <= 1'b0;
        end
        else if (clk_en_i)
        begin
            response_byte_count_o <= rsp_if.count;
            command_byte_count_o  <= cmd_if.count;
            port_status_reg_o     <= pen_s2_q;
            identification_reg_o  <= ID_VALUE;
            engine_busy_o         <= (st_q != SCAP_IDLE);
        end
    end

endmodule // scap_top
`default_nettype wire

// ---- core/scap_pkg.sv ----
// Shared constants and types of the scan chain access port
//
// Function
// - Response buffer is exactly seven bytes deep
// - Command buffer holds four to seven bytes
// - Multiplexer routes one of eight scan ports
// - Engine consumes commands, shifts, pushes response bytes
// - Returned scan clock paces every shift step
// - Scan inputs are synchronised before use
// - Status, select and identity never stall
// - Byte read waits until n bytes exist
// - Byte write waits until n bytes fit
// - Status reports available response byte count
// - Status reports queued command byte count
// - Read data is captured scan output only
// - Every command is one eight bit byte
// - Each port has a port enabled input
package scap_pkg;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned ACC_W       = 32;
    localparam int unsigned ACC_BYTES   = 4;
    localparam int unsigned LEN_W       = 3;
    localparam int unsigned RESP_DEPTH  = 7;
    localparam int unsigned CMD_DEPTH   = 4;
    localparam int unsigned CMD_MAX     = 7;
    localparam int unsigned NUM_PORTS   = 8;
    localparam int unsigned SEL_W       = 3;
    localparam int unsigned CNT_W       = 3;
    // Command byte fields
    localparam int unsigned OPC_BIT     = 7;
    localparam int unsigned TDI_BIT     = 6;
    localparam int unsigned MARK_TOP    = 5;
    localparam int unsigned DLEN_W      = 4;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    // Identification value, arbitrary
    localparam logic [31:0] ID_VALUE    = 32'h0000_5A01;

    typedef enum logic [2:0] {
        SCAP_IDLE  = 3'b000,
        SCAP_FETCH = 3'b001,
        SCAP_SETUP = 3'b010,
        SCAP_RISE  = 3'b011,
        SCAP_FALL  = 3'b100,
        SCAP_PUSH  = 3'b101
    } scap_eng_t;
endpackage

// ---- core/scap_byte_if.sv ----
// Byte stream bundle between the access logic and a buffer
`timescale 1ns/1ps
`default_nettype none
interface scap_byte_if #(parameter int unsigned W = 8, parameter int unsigned CW = 3);
    logic [W-1:0]  wdata;
    logic          wvalid;
    logic          wready;
    logic [W-1:0]  rdata;
    logic          rvalid;
    logic          rready;
    logic [CW-1:0] count;
    modport fifo (input wdata, wvalid, rready, output wready, rdata, rvalid, count);
    modport user (output wdata, wvalid, rready, input wready, rdata, rvalid, count);
endinterface
`default_nettype wire

// ---- core/scap_fifo.sv ----
// Byte buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scap_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned CW    = 4
) (
    input  wire logic    ref_clk_i,
    input  wire logic    reset_i,
    input  wire logic    clk_en_i,
    scap_byte_if.fifo    bus
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << CW) <= DEPTH)
            $error("scap_fifo: depth or count width unusable");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;

    ////////////////////////////////////////////////////////////////////////
    // Handshake terms; full and empty come straight from the count
    wire do_push = bus.wvalid && bus.wready && clk_en_i;
    wire do_pop  = bus.rvalid && bus.rready && clk_en_i;
    assign bus.wready = (count_q != CNT_FULL);
    assign bus.rvalid = (count_q != '0);
    assign bus.rdata  = mem_q[rd_ptr_q];
    assign bus.count  = count_q;

    // Storage carries no reset, only pointers and count do
    always_ff @(posedge ref_clk_i)
    begin
        if (do_push)
            mem_q[wr_ptr_q] <= bus.wdata;
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
            if (do_pop)
                rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
            if (do_push && !do_pop)
                count_q <= count_q + 1'b1;
            else if (do_pop && !do_push)
                count_q <= count_q - 1'b1;
        end
    end
endmodule // scap_fifo
`default_nettype wire

// ---- tb/scap_top_props.sv ----
// Port-level checks of the scan chain access port
`timescale 1ns/1ps
`default_nettype none
module scap_top_props
    import scap_pkg::*;
#(
    parameter int unsigned PORTS     = NUM_PORTS,
    parameter int unsigned CMD_BYTES = CMD_DEPTH
) (
    input wire logic             ref_clk_i,
    input wire logic             reset_i,
    input wire logic             bw_req_i,
    input wire logic             bw_ack_o,
    input wire logic             br_req_i,
    input wire logic             br_ack_o,
    input wire logic [ACC_W-1:0] br_data_o,
    input wire logic [SEL_W-1:0] port_sel_i,
    input wire logic [CNT_W-1:0] command_byte_count_o,
    input wire logic [PORTS-1:0] port_status_reg_o,
    input wire logic [ACC_W-1:0] identification_reg_o,
    input wire logic [PORTS-1:0] tck_o,
    input wire logic [PORTS-1:0] tdi_o,
    input wire logic [PORTS-1:0] port_enabled_in_i
);
    logic [2:0]       age_q;
    logic [PORTS-1:0] sel_mask;

    ////////////////////////////////////////////////////////////////
    // Cycles since reset, so pipelined outputs are judged once filled
    always_ff @(posedge ref_clk_i or posedge reset_i)
        if (reset_i)
            age_q <= 3'h0;
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    assign sel_mask = PORTS'(1) << port_sel_i;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////
    // Access handshakes, status mirrors and scan port outputs
    wr_ack_pulse_a: assert property (bw_ack_o |=> !bw_ack_o)
        else $error("write ack longer than one cycle");
    rd_ack_pulse_a: assert property (br_ack_o |=> !br_ack_o)
        else $error("read ack longer than one cycle");
    wr_ack_cause_a: assert property ($rose(bw_ack_o) |-> $past(bw_req_i) && $past(bw_req_i, 2))
        else $error("write ack without a held request");
    rd_ack_cause_a: assert property (br_ack_o |-> $past(br_req_i) && $past(br_req_i, 2))
        else $error("read ack without a held request");
    rd_data_hold_a: assert property (!br_ack_o |-> $stable(br_data_o))
        else $error("read data moved without ack");
    cmd_fill_max_a: assert property (command_byte_count_o <= CMD_BYTES)
        else $error("command fill above depth");
    ident_fixed_a: assert property ((age_q == 3'h7) |-> identification_reg_o == ID_VALUE)
        else $error("identification value wrong");
    status_sync_a: assert property ((age_q == 3'h7) |-> port_status_reg_o == $past(port_enabled_in_i, 3))
        else $error("port status not three cycles behind");
    mux_select_a: assert property ((tck_o & ~sel_mask) == '0)
        else $error("clock on an unselected port");
    bit_stable_a: assert property ($past(|tck_o) && (|tck_o) |-> $stable(tdi_o))
        else $error("data moved while clock high");
endmodule // scap_top_props

bind scap_top scap_top_props #(.PORTS(PORTS), .CMD_BYTES(CMD_BYTES)) u_props (
    .ref_clk_i, .reset_i, .bw_req_i, .bw_ack_o, .br_req_i, .br_ack_o, .br_data_o, .port_sel_i,
    .command_byte_count_o, .port_status_reg_o, .identification_reg_o, .tck_o, .tdi_o, .port_enabled_in_i
);
`default_nettype wire

// ---- tb/scap_scan_model.sv ----
// Behavioural scan chains: clock looped back late, output is inverted input
`timescale 1ns/1ps
`default_nettype none
module scap_scan_model
    import scap_pkg::*;
#(
    parameter int unsigned PORTS   = NUM_PORTS,
    parameter int unsigned LOOP_NS = 40
) (
    input  wire logic [PORTS-1:0] tck_i,
    input  wire logic [PORTS-1:0] tms_i,
    input  wire logic [PORTS-1:0] tdi_i,
    input  wire logic [SEL_W-1:0] sel_i,
    output logic [PORTS-1:0]      ret_clk_o,
    output logic [PORTS-1:0]      tdo_o,
    output logic [7:0]            tms_hist_o,
    output logic                  tdi_seen_o
);
    wire logic sel_tck;
    assign sel_tck = tck_i[sel_i];
    assign tdo_o   = ~tdi_i; // Known answer, never a stale copy

    initial
    begin
        ret_clk_o  = '0;
        tms_hist_o = 8'h00;
        tdi_seen_o = 1'h0;
    end
    // Late return makes each half bit at least LOOP_NS, an 80 ns link period
    always @(tck_i) ret_clk_o <= #(LOOP_NS) tck_i;
    // Record what the selected chain sees at each rising clock
    always @(posedge sel_tck)
    begin
        tms_hist_o <= {tms_hist_o[6:0], tms_i[sel_i]};
        tdi_seen_o <= tdi_i[sel_i];
    end
endmodule // scap_scan_model
`default_nettype wire

// ---- tb/scap_top_bench.sv ----
// Self-checking bench of the scan chain access port
`timescale 1ns/1ps
`default_nettype none
module scap_top_bench
    import scap_pkg::*;
;
    logic             ref_clk_i;
    logic             reset_i;
    logic             bw_req_i;
    logic             bw_ack_o;
    logic             br_req_i;
    logic             br_ack_o;
    logic             busy;
    logic             tdi_seen;
    logic [LEN_W-1:0] bw_len_i;
    logic [LEN_W-1:0] br_len_i;
    logic [ACC_W-1:0] bw_data_i;
    logic [ACC_W-1:0] br_data_o;
    logic [ACC_W-1:0] ident;
    logic [SEL_W-1:0] port_sel_i;
    logic [CNT_W-1:0] resp_cnt;
    logic [CNT_W-1:0] cmd_cnt;
    logic [7:0]       status, tck, tms, tdi, tdo, ret_clk, enabled, tms_hist;
    int               n_errors;
    int               checked;

    always #4 ref_clk_i = ~ref_clk_i;

    scap_top uut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(1'h1),
        .bw_req_i(bw_req_i), .bw_len_i(bw_len_i), .bw_data_i(bw_data_i), .bw_ack_o(bw_ack_o),
        .br_req_i(br_req_i), .br_len_i(br_len_i), .br_ack_o(br_ack_o), .br_data_o(br_data_o),
        .port_sel_i(port_sel_i), .response_byte_count_o(resp_cnt), .command_byte_count_o(cmd_cnt),
        .port_status_reg_o(status), .identification_reg_o(ident), .engine_busy_o(busy),
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
        .returned_scan_clock_i(ret_clk), .port_enabled_in_i(enabled)
    );
    scap_scan_model chains (
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .sel_i(port_sel_i),
        .ret_clk_o(ret_clk), .tdo_o(tdo), .tms_hist_o(tms_hist), .tdi_seen_o(tdi_seen)
    );

    ////////////////////////////////////////////////////////////////
    // Shared helpers; inputs always move 1 ns after a rising edge
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // One buffer access, held until its ack; k returns the wait in cycles
    task automatic xfer(input logic rd, input logic [2:0] n, input logic [31:0] d, output int k);
        bw_len_i = n;
        br_len_i = n;
        bw_data_i = d;
        br_req_i = rd;
        bw_req_i = !rd;
        k = 0;
        do
        begin
            tick(1);
            k++;
        end
        while ((rd ? br_ack_o : bw_ack_o) !== 1'h1 && k < 3000);
        br_req_i = 1'h0;
        bw_req_i = 1'h0;
        chk("access ack", rd ? br_ack_o : bw_ack_o, 32'h1);
        tick(1);
    endtask

    // Bounded wait for a response fill, optionally with the engine drained
    task automatic settle(input logic [2:0] n, input logic idle);
        int k;
        k = 0;
        tick(4);
        while (!(resp_cnt === n && (!idle || (cmd_cnt === 3'h0 && busy === 1'h0))) && k < 5000)
        begin
            tick(1);
            k++;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_idle;
        chk("ident", ident, ID_VALUE);
        chk("status", status, 32'hDF);
        chk("resp count", resp_cnt, 32'h0);
        chk("cmd count", cmd_cnt, 32'h0);
        $display("test idle done");
    endtask

    task automatic t_queue;
        int k;
        port_sel_i = 3'h5;
        xfer(1'h0, 3'h2, 32'h0000_A580, k);
        tick(30);
        chk("held cmd count", cmd_cnt, 32'h2);
        chk("held resp count", resp_cnt, 32'h0);
        enabled[5] = 1'h1;
        settle(3'h1, 1'h1);
        chk("scan resp count", resp_cnt, 32'h1);
        xfer(1'h1, 3'h1, 32'h0, k);
        chk("scan byte", br_data_o, 32'h0000_005A);
        $display("test queue done");
    endtask

    task automatic t_tms;
        int k;
        port_sel_i = 3'h2;
        xfer(1'h0, 3'h1, 32'h0000_004B, k);
        settle(3'h0, 1'h1);
        chk("tms bits", tms_hist[2:0], 32'h6);
        chk("tms tdi level", tdi_seen, 32'h1);
        chk("no capture", resp_cnt, 32'h0);
        $display("test tms done");
    endtask

    // Eight data bytes against a seven byte response buffer
    task automatic t_deep;
        int k;
        xfer(1'h0, 3'h4, 32'h3322_1187, k);
        xfer(1'h0, 3'h4, 32'h7766_5544, k);
        chk("write stalled", k > 20, 32'h1);
        xfer(1'h0, 3'h1, 32'h0000_0088, k);
        settle(3'h7, 1'h0);
        tick(100);
        chk("full resp count", resp_cnt, 32'h7);
        chk("engine waits", busy, 32'h1);
        xfer(1'h1, 3'h4, 32'h0, k);
        chk("first word", br_data_o, 32'hBBCC_DDEE);
        xfer(1'h1, 3'h4, 32'h0, k);
        chk("second word", br_data_o, 32'h7788_99AA);
        $display("test deep done");
    endtask

    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Watchdog: the tests need some 14 us
    initial
    begin
        #400000;
        n_errors++;
        $display("watchdog expired");
        test_done;
    end

    initial
    begin
        ref_clk_i = 1'h0;
        reset_i = 1'h1;
        bw_req_i = 1'h0;
        br_req_i = 1'h0;
        bw_len_i = 3'h1;
        br_len_i = 3'h1;
        bw_data_i = 32'h0;
        port_sel_i = 3'h0;
        enabled = 8'hDF;
        n_errors = 0;
        checked = 0;
        tick(2);
        reset_i = 1'h0;
        tick(8);
        t_idle;
        t_queue;
        t_tms;
        t_deep;
        test_done;
    end
endmodule // scap_top_bench
`default_nettype wire
